// *** hdl/gfdc_pkg.sv ***
// Constants, timing figures and types for the gauge filament and degas control.
// Assumes a single 25 MHz clock; all slow timing runs off a 1 ms enable.
package gfdc_pkg;

  localparam int CLK_HZ          = 25_000_000;
  localparam int TICK_US         = 1000;
  localparam int TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TICK_W          = 16;

  localparam int REQ_LOW_MS      = 25;
  localparam int REQ_HIGH_MS     = 105;
  localparam int QUAL_W          = 8;

  localparam int START_DELAY_S   = 2;
  localparam int START_DELAY_MS  = START_DELAY_S * 1000;
  localparam int UPD_FAST_MS     = 500;
  localparam int UPD_SLOW_S      = 3;
  localparam int UPD_SLOW_MS     = UPD_SLOW_S * 1000;
  localparam int DEGAS_LIMIT_MIN = 15;
  localparam int DEGAS_LIMIT_MS  = DEGAS_LIMIT_MIN * 60 * 1000;
  localparam int PHASE_W         = 20;
  localparam int UPD_W           = 12;

  localparam int WDOG_TIMEOUT_MS = 100;
  localparam int WDOG_PULSE_MS   = 10;
  localparam int WDOG_W          = 8;

  // Pressure thresholds, mantissa as two BCD digits d.d
  localparam logic signed [7:0] DEGAS_EXP_LIM  = -8'sh05;
  localparam logic        [7:0] DEGAS_MANT_LIM = 8'h50;
  localparam logic        [7:0] TRIP_MANT      = 8'h10;
  localparam logic signed [7:0] TRIP_EXP_R0    = -8'sh03;
  localparam logic signed [7:0] TRIP_EXP_R1    = -8'sh04;
  localparam logic signed [7:0] TRIP_EXP_R2    = -8'sh05;

  localparam int NUM_REQ   = 6;
  localparam int REQ_FIL1  = 0;
  localparam int REQ_FIL2  = 1;
  localparam int REQ_DEGAS = 2;
  localparam int REQ_REM   = 3;

  typedef enum logic [1:0] {GFDC_OFF, GFDC_START, GFDC_ON, GFDC_DEGAS} gfdc_state_t;
  typedef enum logic {GFDC_Q_ARMED, GFDC_Q_REARM} gfdc_qual_t;

endpackage

// *** hdl/gfdc_req_qual.sv ***
// One request input qualifier: synchroniser, low-time check, rearm gap.
// Assumes a 1 ms enable pulse on tick from the same clock domain.
`timescale 1ns/10ps
module gfdc_req_qual (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic pin_n,
  output logic      req
);

  localparam int QUAL_W = gfdc_pkg::QUAL_W;

  logic                         meta_r;
  logic                         sync_r;
  gfdc_pkg::gfdc_qual_t         qstate_r;
  logic [gfdc_pkg::QUAL_W-1:0]  cnt_r;

  // Undriven pins idle high, so reset loads idle
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      meta_r <= 1'b1; // [RQ12]
      sync_r <= 1'b1;
    end
    else
    begin
      meta_r <= pin_n; // [RQ21]
      sync_r <= meta_r;
    end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      qstate_r <= gfdc_pkg::GFDC_Q_ARMED;
      cnt_r    <= '0;
      req      <= 1'b0;
    end
    else
    begin
      req <= 1'b0;
      unique case (qstate_r)
        gfdc_pkg::GFDC_Q_ARMED:
        begin
          if (sync_r)
            cnt_r <= '0;
          else if (tick && cnt_r == QUAL_W'(gfdc_pkg::REQ_LOW_MS - 1))
          begin
            req      <= 1'b1; // [RQ10] [RQ21]
            cnt_r    <= '0;
            qstate_r <= gfdc_pkg::GFDC_Q_REARM;
          end
          else if (tick)
            cnt_r <= cnt_r + 1'b1;
        end
        gfdc_pkg::GFDC_Q_REARM:
        begin
          if (!sync_r)
            cnt_r <= '0; // [RQ11]
          else if (tick && cnt_r == QUAL_W'(gfdc_pkg::REQ_HIGH_MS - 1))
          begin
            cnt_r    <= '0;
            qstate_r <= gfdc_pkg::GFDC_Q_ARMED;
          end
          else if (tick)
            cnt_r <= cnt_r + 1'b1;
        end
      endcase
    end

  property p_req_after_low;
    @(posedge clk) disable iff (!rst_n)
    req |-> $past(qstate_r) == gfdc_pkg::GFDC_Q_ARMED && !$past(sync_r) && $past(tick);
  endproperty
  a_req_after_low: assert property (p_req_after_low) // [RQ10]
    else $error("request pulse without qualified low");

  property p_no_rearm_early;
    @(posedge clk) disable iff (!rst_n)
    req |=> qstate_r == gfdc_pkg::GFDC_Q_REARM && cnt_r == '0;
  endproperty
  a_no_rearm_early: assert property (p_no_rearm_early) // [RQ11]
    else $error("qualifier not waiting for high gap");

endmodule // gfdc_req_qual

// *** hdl/gfdc_top.sv ***
// Gauge filament and degas control: requests, interlocks, timers, display.
// Assumes pressure readings arrive from electrometer logic on CLK; pins are async.
`timescale 1ns/10ps
// Overview of operation
// RQ1: Filament request turns gauge on, that filament
// RQ2: Same filament request while on turns off
// RQ3: Show pressure two seconds after turn-on
// RQ4: Degas request toggles degas on and off
// RQ5: Filament request during degas ends degas
// RQ6: Degas ends automatically after fifteen minutes
// RQ7: Degas needs gauge on, pressure below 5e-5
// RQ8: Degas indicator lit exactly while degas active
// RQ9: Three active-low remote inputs mirror panel switches
// RQ10: Remote low must last 25 ms
// RQ11: High gap 105 ms before next request
// RQ12: Undriven remote inputs read as idle high
// RQ13: Filament status output active while filament on
// RQ14: Display every 0.5 s, slow: averaged 3 s
// RQ15: Display two-digit mantissa plus exponent
// RQ16: Overpressure one decade below range limit trips
// RQ17: Watchdog resets controller on missed checkpoints
// RQ18: Display bus carries BCD digits
// RQ19: Timer override disables fifteen-minute degas stop
// RQ20: Gauge off ends degas, clears status
// RQ21: Inputs synchronised, qualified, one pulse each
module gfdc_top #(
  parameter int TICK_CYCLES    = gfdc_pkg::TICK_CYCLES,
  parameter int DEGAS_LIMIT_MS = gfdc_pkg::DEGAS_LIMIT_MS
) (
  input  wire logic              CLK,
  input  wire logic              RESETN,
  input  wire logic              PANEL_FIL1_N,
  input  wire logic              PANEL_FIL2_N,
  input  wire logic              PANEL_DEGAS_N,
  input  wire logic              REMOTE_FIL1_N,
  input  wire logic              REMOTE_FIL2_N,
  input  wire logic              REMOTE_DEGAS_N,
  input  wire logic              SLOW_UPDATE,
  input  wire logic              DEGAS_TIMER_OVERRIDE,
  input  wire logic [1:0]        EMIS_RANGE,
  input  wire logic              PRESS_VALID,
  input  wire logic [7:0]        PRESS_MANT,
  input  wire logic signed [7:0] PRESS_EXP,
  input  wire logic              CPU_CHECKPOINT,
  output logic                   FIL1_ON,
  output logic                   FIL2_ON,
  output logic                   FIL_STATUS,
  output logic                   ION_SENSOR_TUBE_DEGAS,
  output logic                   DEGAS_LED,
  output logic                   DISP_VALID,
  output logic                   DISP_STROBE,
  output logic [7:0]             DISP_MANT,
  output logic                   DISP_EXP_NEG,
  output logic [7:0]             DISP_EXP,
  output logic                   CPU_RESET_N
);

  localparam int PHASE_W = gfdc_pkg::PHASE_W;
  localparam int TICK_W  = gfdc_pkg::TICK_W;
  localparam int UPD_W   = gfdc_pkg::UPD_W;
  localparam int WDOG_W  = gfdc_pkg::WDOG_W;

  logic [1:0]                  rst_sync_r;
  logic                        rst_n;
  logic [1:0]                  cfg_meta_r;
  logic [1:0]                  cfg_r;
  logic                        slow_mode;
  logic                        timer_override;
  logic [TICK_W-1:0]           tick_cnt_r;
  logic                        tick_r;
  logic [gfdc_pkg::NUM_REQ-1:0] req_pin_n;
  logic [gfdc_pkg::NUM_REQ-1:0] req_pulse;
  logic [1:0]                  fil_req;
  logic                        degas_req;
  gfdc_pkg::gfdc_state_t       state_r;
  gfdc_pkg::gfdc_state_t       state_nxt;
  logic                        sel_r;
  logic                        sel_nxt;
  logic [PHASE_W-1:0]          phase_ms_r;
  logic                        start_done;
  logic                        degas_done;
  logic                        press_seen_r;
  logic [7:0]                  press_mant_r;
  logic signed [7:0]           press_exp_r;
  logic                        press_ok;
  logic signed [7:0]           trip_exp;
  logic                        trip;
  logic [6:0]                  avg_r;
  logic signed [7:0]           avg_exp_r;
  logic [8:0]                  avg_sum;
  logic [UPD_W-1:0]            upd_ms_r;
  logic                        upd_due;
  logic                        disp_ok;
  logic [WDOG_W-1:0]           wd_ms_r;
  logic                        wd_fire;

  function automatic logic [6:0] bcd2bin(input logic [7:0] b);
    bcd2bin = {3'h0, b[7:4]} * 7'h0a + {3'h0, b[3:0]};
  endfunction

  function automatic logic [7:0] bin2bcd(input logic [6:0] v);
    bin2bcd = {4'(v / 7'd10), 4'(v % 7'd10)};
  endfunction

  // Reset release through two flops
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};

  assign rst_n = rst_sync_r[1];

  // Internal configuration switches are asynchronous pins
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      cfg_meta_r <= 2'b00;
      cfg_r      <= 2'b00;
    end
    else
    begin
      cfg_meta_r <= {DEGAS_TIMER_OVERRIDE, SLOW_UPDATE};
      cfg_r      <= cfg_meta_r;
    end

  assign slow_mode      = cfg_r[0];
  assign timer_override = cfg_r[1];

  // 1 ms enable
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end
    else
    begin
      tick_r     <= (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));
      tick_cnt_r <= (tick_cnt_r == TICK_W'(TICK_CYCLES - 1)) ? '0 : tick_cnt_r + 1'b1;
    end

  assign req_pin_n = {REMOTE_DEGAS_N, REMOTE_FIL2_N, REMOTE_FIL1_N,
                      PANEL_DEGAS_N, PANEL_FIL2_N, PANEL_FIL1_N};

  // Panel and remote inputs get one qualifier each, six in all
  for (genvar i = 0; i < gfdc_pkg::NUM_REQ; i++)
  begin : g_qual
    gfdc_req_qual u_qual (
      .clk   (CLK),
      .rst_n (rst_n),
      .tick  (tick_r),
      .pin_n (req_pin_n[i]),
      .req   (req_pulse[i])
    );
  end

  assign fil_req[0] = req_pulse[gfdc_pkg::REQ_FIL1] |
                      req_pulse[gfdc_pkg::REQ_REM + gfdc_pkg::REQ_FIL1]; // [RQ9]
  assign fil_req[1] = req_pulse[gfdc_pkg::REQ_FIL2] |
                      req_pulse[gfdc_pkg::REQ_REM + gfdc_pkg::REQ_FIL2]; // [RQ9]
  assign degas_req  = req_pulse[gfdc_pkg::REQ_DEGAS] |
                      req_pulse[gfdc_pkg::REQ_REM + gfdc_pkg::REQ_DEGAS]; // [RQ9]

  // Latest reading, forgotten while the gauge is off
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      press_seen_r <= 1'b0;
      press_mant_r <= '0;
      press_exp_r  <= '0;
    end
    else if (state_r == gfdc_pkg::GFDC_OFF)
      press_seen_r <= 1'b0;
    else if (PRESS_VALID)
    begin
      press_seen_r <= 1'b1;
      press_mant_r <= PRESS_MANT;
      press_exp_r  <= PRESS_EXP;
    end

  assign press_ok = press_seen_r && (press_exp_r < gfdc_pkg::DEGAS_EXP_LIM ||
                    (press_exp_r == gfdc_pkg::DEGAS_EXP_LIM &&
                     press_mant_r < gfdc_pkg::DEGAS_MANT_LIM)); // [RQ7]

  always_comb
  begin
    unique case (EMIS_RANGE)
      2'b00:   trip_exp = gfdc_pkg::TRIP_EXP_R0;
      2'b01:   trip_exp = gfdc_pkg::TRIP_EXP_R1;
      default: trip_exp = gfdc_pkg::TRIP_EXP_R2;
    endcase
  end

  assign trip = PRESS_VALID && (PRESS_EXP > trip_exp ||
                (PRESS_EXP == trip_exp && PRESS_MANT > gfdc_pkg::TRIP_MANT)); // [RQ16]

  assign start_done = phase_ms_r >= PHASE_W'(gfdc_pkg::START_DELAY_MS); // [RQ3]
  assign degas_done = !timer_override &&
                      phase_ms_r >= PHASE_W'(DEGAS_LIMIT_MS); // [RQ6] [RQ19]

  // Trip first, then filament, then degas, then timers
  always_comb
  begin
    state_nxt = state_r;
    sel_nxt   = sel_r;
    if (state_r != gfdc_pkg::GFDC_OFF && trip)
      state_nxt = gfdc_pkg::GFDC_OFF; // [RQ16] [RQ20]
    else if (fil_req != 2'b00)
    begin
      sel_nxt = !fil_req[0];
      unique case (state_r)
        gfdc_pkg::GFDC_OFF:
          state_nxt = gfdc_pkg::GFDC_START; // [RQ1]
        gfdc_pkg::GFDC_START, gfdc_pkg::GFDC_ON:
          state_nxt = (sel_nxt == sel_r) ? gfdc_pkg::GFDC_OFF : gfdc_pkg::GFDC_START; // [RQ2]
        gfdc_pkg::GFDC_DEGAS:
          state_nxt = (sel_nxt == sel_r) ? gfdc_pkg::GFDC_ON : gfdc_pkg::GFDC_START; // [RQ5]
      endcase
    end
    else if (degas_req)
    begin
      if (state_r == gfdc_pkg::GFDC_ON && press_ok)
        state_nxt = gfdc_pkg::GFDC_DEGAS; // [RQ4] [RQ7]
      else if (state_r == gfdc_pkg::GFDC_DEGAS)
        state_nxt = gfdc_pkg::GFDC_ON; // [RQ4]
    end
    else if (state_r == gfdc_pkg::GFDC_START && start_done)
      state_nxt = gfdc_pkg::GFDC_ON; // [RQ3]
    else if (state_r == gfdc_pkg::GFDC_DEGAS && degas_done)
      state_nxt = gfdc_pkg::GFDC_ON; // [RQ6]
  end

  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      state_r <= gfdc_pkg::GFDC_OFF;
      sel_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      sel_r   <= sel_nxt;
    end

  // Time spent in the current state, in ms
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
      phase_ms_r <= '0;
    else if (state_nxt != state_r)
      phase_ms_r <= '0;
    else if (tick_r && !(&phase_ms_r))
      phase_ms_r <= phase_ms_r + 1'b1;

  // Drive outputs from next state so they align with state_r
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      FIL1_ON               <= 1'b0;
      FIL2_ON               <= 1'b0;
      FIL_STATUS            <= 1'b0;
      ION_SENSOR_TUBE_DEGAS <= 1'b0;
      DEGAS_LED             <= 1'b0;
      DISP_VALID            <= 1'b0;
    end
    else
    begin
      FIL1_ON               <= state_nxt != gfdc_pkg::GFDC_OFF && !sel_nxt; // [RQ1]
      FIL2_ON               <= state_nxt != gfdc_pkg::GFDC_OFF && sel_nxt; // [RQ1]
      FIL_STATUS            <= state_nxt != gfdc_pkg::GFDC_OFF; // [RQ13] [RQ20]
      ION_SENSOR_TUBE_DEGAS <= state_nxt == gfdc_pkg::GFDC_DEGAS; // [RQ4]
      DEGAS_LED             <= state_nxt == gfdc_pkg::GFDC_DEGAS; // [RQ8]
      DISP_VALID            <= disp_ok; // [RQ3]
    end

  // Slow mode keeps a running 3:1 average of mantissas within one decade
  assign avg_sum = {2'h0, avg_r} * 9'h003 + {2'h0, bcd2bin(PRESS_MANT)};

  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      avg_r     <= '0;
      avg_exp_r <= '0;
    end
    else if (PRESS_VALID)
    begin
      avg_exp_r <= PRESS_EXP;
      if (slow_mode && PRESS_EXP == avg_exp_r)
        avg_r <= avg_sum[8:2]; // [RQ14]
      else
        avg_r <= bcd2bin(PRESS_MANT);
    end

  assign disp_ok = state_nxt == gfdc_pkg::GFDC_ON || state_nxt == gfdc_pkg::GFDC_DEGAS;

  // At or past period end, so a mode switch cannot miss it
  assign upd_due = tick_r && upd_ms_r >= (slow_mode ? UPD_W'(gfdc_pkg::UPD_SLOW_MS - 1)
                                                    : UPD_W'(gfdc_pkg::UPD_FAST_MS - 1));

  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
      upd_ms_r <= '0;
    else if (upd_due)
      upd_ms_r <= '0; // [RQ14]
    else if (tick_r)
      upd_ms_r <= upd_ms_r + 1'b1;

  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      DISP_STROBE  <= 1'b0;
      DISP_MANT    <= '0;
      DISP_EXP_NEG <= 1'b0;
      DISP_EXP     <= '0;
    end
    else
    begin
      // Next state gates it, so no strobe lands in START or OFF
      DISP_STROBE <= upd_due && disp_ok; // [RQ3]
      if (upd_due && disp_ok)
      begin
        DISP_MANT    <= bin2bcd(avg_r); // [RQ15] [RQ18]
        DISP_EXP_NEG <= avg_exp_r[7];
        DISP_EXP     <= bin2bcd(avg_exp_r[7] ? 7'(-avg_exp_r) : avg_exp_r[6:0]); // [RQ18]
      end
    end

  // Watchdog on controller checkpoints, then a fixed reset pulse
  assign wd_fire = tick_r && CPU_RESET_N &&
                   wd_ms_r == WDOG_W'(gfdc_pkg::WDOG_TIMEOUT_MS - 1);

  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      wd_ms_r     <= '0;
      CPU_RESET_N <= 1'b1;
    end
    else if (wd_fire)
    begin
      wd_ms_r     <= '0;
      CPU_RESET_N <= 1'b0; // [RQ17]
    end
    else if (!CPU_RESET_N)
    begin
      if (tick_r && wd_ms_r == WDOG_W'(gfdc_pkg::WDOG_PULSE_MS - 1))
      begin
        wd_ms_r     <= '0;
        CPU_RESET_N <= 1'b1;
      end
      else if (tick_r)
        wd_ms_r <= wd_ms_r + 1'b1;
    end
    else if (CPU_CHECKPOINT)
      wd_ms_r <= '0;
    else if (tick_r)
      wd_ms_r <= wd_ms_r + 1'b1;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  property p_fil1_on;
    state_r == gfdc_pkg::GFDC_OFF && fil_req == 2'b01 |=> FIL1_ON && !FIL2_ON;
  endproperty
  a_fil1_on: assert property (p_fil1_on) // [RQ1]
    else $error("filament 1 request did not light filament 1");

  property p_toggle_off;
    state_r == gfdc_pkg::GFDC_ON && !trip && !sel_r && fil_req == 2'b01
      |=> !FIL1_ON && !FIL2_ON;
  endproperty
  a_toggle_off: assert property (p_toggle_off) // [RQ2]
    else $error("repeat filament request did not turn gauge off");

  property p_no_disp_start;
    state_r == gfdc_pkg::GFDC_START |-> !DISP_VALID && !DISP_STROBE;
  endproperty
  a_no_disp_start: assert property (p_no_disp_start) // [RQ3]
    else $error("pressure shown during start delay");

  property p_degas_on;
    state_r == gfdc_pkg::GFDC_ON && !trip && fil_req == 2'b00 && degas_req && press_ok
      |=> ION_SENSOR_TUBE_DEGAS;
  endproperty
  a_degas_on: assert property (p_degas_on) // [RQ4]
    else $error("accepted degas request did not start degas");

  property p_fil_ends_degas;
    ION_SENSOR_TUBE_DEGAS && !trip && fil_req != 2'b00 |=> !ION_SENSOR_TUBE_DEGAS && FIL_STATUS;
  endproperty
  a_fil_ends_degas: assert property (p_fil_ends_degas) // [RQ5]
    else $error("filament request did not end degas");

  property p_degas_limit;
    ION_SENSOR_TUBE_DEGAS && !timer_override && !$past(timer_override)
      |-> phase_ms_r <= PHASE_W'(DEGAS_LIMIT_MS);
  endproperty
  a_degas_limit: assert property (p_degas_limit) // [RQ6] [RQ19]
    else $error("degas ran past its time limit");

  property p_degas_interlock;
    $rose(ION_SENSOR_TUBE_DEGAS) |-> $past(state_r) == gfdc_pkg::GFDC_ON && $past(press_ok);
  endproperty
  a_degas_interlock: assert property (p_degas_interlock) // [RQ7]
    else $error("degas started without gauge on and low pressure");

  property p_led_follows;
    DEGAS_LED == ION_SENSOR_TUBE_DEGAS && DEGAS_LED == (state_r == gfdc_pkg::GFDC_DEGAS);
  endproperty
  a_led_follows: assert property (p_led_follows) // [RQ8]
    else $error("degas indicator differs from degas state");

  property p_status;
    FIL_STATUS == (FIL1_ON || FIL2_ON) && !(FIL1_ON && FIL2_ON);
  endproperty
  a_status: assert property (p_status) // [RQ13]
    else $error("filament status wrong");

  property p_trip_off;
    state_r != gfdc_pkg::GFDC_OFF && trip |=> !FIL_STATUS && !ION_SENSOR_TUBE_DEGAS;
  endproperty
  a_trip_off: assert property (p_trip_off) // [RQ16] [RQ20]
    else $error("overpressure did not shut gauge off");

endmodule // gfdc_top

// *** sim/gfdc_remote_model.sv ***
// Remote equipment model: drives the three active-low request lines.
// Assumes the bench pulses go for one cycle, then waits for busy to drop.
`timescale 1ns/10ps
module gfdc_remote_model #(
  parameter int TICK = 4
) (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [1:0] sel,
  input  wire logic [7:0] low_ms,
  input  wire logic [7:0] gap_ms,
  output logic            busy,
  output logic            fil1_n,
  output logic            fil2_n,
  output logic            degas_n
);
  logic [2:0] pins_n_r = 3'b111;

  assign fil1_n  = pins_n_r[0];
  assign fil2_n  = pins_n_r[1];
  assign degas_n = pins_n_r[2];

  initial
  begin
    busy = 1'b0;
    forever
    begin
      @(posedge clk);
      if (go)
      begin
        busy     <= 1'b1;
        pins_n_r <= ~(3'b001 << sel);
        repeat (low_ms * TICK) @(posedge clk);
        pins_n_r <= 3'b111;
        repeat (gap_ms * TICK) @(posedge clk);
        busy <= 1'b0;
      end
    end
  end
endmodule // gfdc_remote_model

// *** sim/tb.sv ***
// Testbench for gfdc_top: requests, degas, display, trip and watchdog.
// Assumes a short tick of T cycles, so one millisecond lasts T cycles.
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) \
    begin \
      failures++; \
      $display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module tb;
  localparam int T = 4;
  int                failures = 0;
  int                n_checks = 0;
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic [2:0]        pan_n = 3'b111;
  logic              slow = 1'b0;
  logic              ovr = 1'b0;
  logic              pv = 1'b0;
  logic              ckp = 1'b0;
  logic              wd_en = 1'b1;
  logic              go = 1'b0;
  logic [1:0]        rng = 2'h0;
  logic [1:0]        sel = 2'h0;
  logic [7:0]        mant = 8'h00;
  logic signed [7:0] pexp = 8'sh00;
  logic [7:0]        low_ms = 8'h00;
  logic [7:0]        gap_ms = 8'h00;
  logic              busy, r1_n, r2_n, rd_n, fil1, fil2, fst, tube, led, dv, ds, dneg, crn;
  logic [7:0]        dm, de;

  gfdc_top #(.TICK_CYCLES(T), .DEGAS_LIMIT_MS(50)) DUT (
    .CLK(clk), .RESETN(resetn), .PANEL_FIL1_N(pan_n[0]), .PANEL_FIL2_N(pan_n[1]),
    .PANEL_DEGAS_N(pan_n[2]), .REMOTE_FIL1_N(r1_n), .REMOTE_FIL2_N(r2_n),
    .REMOTE_DEGAS_N(rd_n), .SLOW_UPDATE(slow), .DEGAS_TIMER_OVERRIDE(ovr),
    .EMIS_RANGE(rng), .PRESS_VALID(pv), .PRESS_MANT(mant), .PRESS_EXP(pexp),
    .CPU_CHECKPOINT(ckp), .FIL1_ON(fil1), .FIL2_ON(fil2), .FIL_STATUS(fst),
    .ION_SENSOR_TUBE_DEGAS(tube), .DEGAS_LED(led), .DISP_VALID(dv), .DISP_STROBE(ds),
    .DISP_MANT(dm), .DISP_EXP_NEG(dneg), .DISP_EXP(de), .CPU_RESET_N(crn));

  gfdc_remote_model #(.TICK(T)) remote_eq (
    .clk(clk), .go(go), .sel(sel), .low_ms(low_ms), .gap_ms(gap_ms), .busy(busy),
    .fil1_n(r1_n), .fil2_n(r2_n), .degas_n(rd_n));

  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic give_verdict;
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hang;
    failures++;
    give_verdict();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Keeps the watchdog fed unless a scenario stops it
  initial
  begin
    forever
    begin
      cyc(10 * T);
      ckp = wd_en;
      cyc(1);
      ckp = 1'b0;
    end
  end

  task automatic remote(input int s, input int lo, input int gp);
    int i;
    @(negedge clk);
    sel    = s[1:0];
    low_ms = lo[7:0];
    gap_ms = gp[7:0];
    go     = 1'b1;
    cyc(1);
    go = 1'b0;
    for (i = 0; i < 600 * T && busy === 1'b1; i++)
      cyc(1);
    if (busy !== 1'b0)
      hang();
  endtask

  task automatic panel(input int s, input int lo, input int gp);
    @(negedge clk);
    pan_n[s] = 1'b0;
    cyc(lo * T);
    pan_n[s] = 1'b1;
    cyc(gp * T);
  endtask

  task automatic reading(input logic [7:0] m, input logic signed [7:0] e);
    @(negedge clk);
    mant = m;
    pexp = e;
    pv   = 1'b1;
    cyc(1);
    pv = 1'b0;
  endtask

  task automatic wait_strobe(output int n);
    for (n = 1; n < 16000; n++)
    begin
      cyc(1);
      if (ds === 1'b1)
        break;
    end
    if (n == 16000)
      hang();
  endtask

  task automatic t_on;
    remote(0, 30, 110);
    `CHK("fil1", 1'b1, fil1)
    `CHK("fil2", 1'b0, fil2)
    `CHK("status", 1'b1, fst)
    cyc(1800 * T);
    `CHK("valid early", 1'b0, dv)
    cyc(200 * T);
    `CHK("valid", 1'b1, dv)
  endtask

  task automatic t_disp;
    int n;
    reading(8'h25, -8'sh06);
    wait_strobe(n);
    `CHK("mant", 8'h25, dm)
    `CHK("sign", 1'b1, dneg)
    `CHK("exp", 8'h06, de)
    wait_strobe(n);
    `CHK("fast period", 500 * T, n)
    slow = 1'b1;
    cyc(3);
    reading(8'h45, -8'sh06);
    wait_strobe(n);
    wait_strobe(n);
    wait_strobe(n);
    `CHK("slow period", 3000 * T, n)
    `CHK("slow average", 8'h30, dm)
    slow = 1'b0;
  endtask

  task automatic t_degas;
    ovr = 1'b1;
    reading(8'h50, -8'sh05);
    panel(2, 30, 110);
    `CHK("degas refused", 1'b0, led)
    reading(8'h49, -8'sh05);
    panel(2, 30, 110);
    `CHK("degas on", 1'b1, tube)
    `CHK("led on", 1'b1, led)
    remote(2, 30, 110);
    `CHK("degas off", 1'b0, tube)
    `CHK("led off", 1'b0, led)
    panel(2, 30, 110);
    panel(0, 30, 110);
    `CHK("fil ends degas", 1'b0, tube)
    `CHK("fil stays", 1'b1, fil1)
    ovr = 1'b0;
    reading(8'h49, -8'sh05);
    panel(2, 30, 10);
    `CHK("timed on", 1'b1, led)
    cyc(60 * T);
    `CHK("timed off", 1'b0, tube)
    cyc(100 * T);
  endtask

  task automatic t_toggle;
    remote(1, 30, 110);
    `CHK("other fil2", 1'b1, fil2)
    `CHK("other fil1", 1'b0, fil1)
    remote(1, 30, 110);
    `CHK("toggle off", 1'b0, fil2)
    `CHK("status off", 1'b0, fst)
    panel(2, 30, 110);
    `CHK("degas when off", 1'b0, led)
  endtask

  task automatic t_qual;
    remote(0, 10, 110);
    `CHK("short low", 1'b0, fil1)
    remote(0, 30, 20);
    remote(0, 30, 110);
    `CHK("short gap", 1'b1, fil1)
    remote(0, 60, 110);
    `CHK("long low", 1'b0, fil1)
  endtask

  task automatic t_trip;
    int r;
    for (r = 0; r < 3; r++)
    begin
      rng = r[1:0];
      remote(0, 30, 110);
      reading(8'h10, 8'(-3 - r));
      cyc(3);
      `CHK("at limit", 1'b1, fil1)
      reading(8'h11, 8'(-3 - r));
      cyc(3);
      `CHK("tripped", 1'b0, fil1)
      `CHK("trip status", 1'b0, fst)
    end
  endtask

  task automatic t_wdog;
    int i;
    wd_en = 1'b0;
    cyc(88 * T);
    `CHK("wd hold", 1'b1, crn)
    for (i = 0; i < 20 * T && crn !== 1'b0; i++)
      cyc(1);
    `CHK("wd fire", 1'b0, crn)
    cyc(12 * T);
    `CHK("wd end", 1'b1, crn)
    wd_en = 1'b1;
  endtask

  initial
  begin
    cyc(5);
    resetn = 1'b1;
    cyc(4);
    t_on();
    t_disp();
    t_degas();
    t_toggle();
    t_qual();
    t_trip();
    t_wdog();
    give_verdict();
  end
endmodule // tb
